// >>> ccm_datapath.v
// Execution datapath for compare, sign count, decrement, interrupt disable and dual MAC
// Functional notes
// - Long compare forms accumulator minus shifted product; flags only, registers untouched.
// - Long compare negative flag is sign of exact wide difference.
// - Long compare zero flag set when difference is zero.
// - Compare and decrement: carry cleared on borrow, set otherwise.
// - Product shift: positive left with zero fill, negative arithmetic right.
// - Non-repeatable ops clear the repeat counter and execute once.
// - Aux compare uses aux reg zero and pointer-selected aux reg, unmodified.
// - Aux compare sets test flag per variant: eq, gt, lt, ne.
// - Three-bit aux pointer selects one of eight aux registers.
// - Sign count writes leading identical bits minus one to temporary register.
// - After sign count: N from bit 31, Z if zero, test flag from sign.
// - Decrement subtracts one from 16-bit operand and writes it back.
// - Decrement sets N from bit 15, Z if zero, V only on overflow.
// - Interrupt disable sets global mask, two cycles, no effect on NMI.
// - Dual MAC adds high product to accumulator, low product to product register.
// - Dual MAC flags and overflow counter come from accumulator operation only.
// - Second dual MAC operand fetched via ext aux reg seven, optional post-increment.
// - First operand's change to ext aux reg seven wins over second.
// - Saturation off: overflow counter up on positive, down on negative overflow.
// - Saturation on: overflowing accumulator clamps to max positive or negative.
`timescale 1ns/1ps
`include "ccm_defs.vh"

module ccm_datapath (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire        i_valid,
  input  wire [3:0]  i_op,
  input  wire [1:0]  i_compare_aux_op_var,
  input  wire        i_repeat_active,
  input  wire [2:0]  i_product_shift_field,
  input  wire        i_saturate_mode,
  input  wire [2:0]  i_aux_pointer_field,
  input  wire [127:0] i_aux_regs,
  input  wire [15:0] i_mem16,
  input  wire [31:0] i_op1_32,
  input  wire [31:0] i_op2_32,
  input  wire [21:0] i_ext_aux_reg_seven,
  input  wire        i_op1_mod_ext_aux_reg_seven,
  input  wire [21:0] i_op1_ext_aux_reg_seven_new,
  input  wire        i_op2_postinc,
  input  wire        i_c_in,
  input  wire        i_v_in,
  output reg  [31:0] o_accumulator_reg,
  output reg  [31:0] o_product_reg,
  output reg  [15:0] o_temp_reg,
  output reg  [5:0]  o_ovc,
  output reg         o_flag_n,
  output reg         o_flag_z,
  output reg         o_flag_c,
  output reg         o_flag_v,
  output reg         o_test_condition_flag,
  output reg         o_global_int_mask,
  output reg         o_clear_repeat_counter,
  output reg  [15:0] o_mem_wdata,
  output reg         o_mem_we,
  output reg  [21:0] o_ext_aux_reg_seven_addr,
  output reg         o_ext_aux_reg_seven_we,
  output reg  [21:0] o_ext_aux_reg_seven_new,
  output wire        o_busy
);

  // ==========================================================
  // Behaviour summary
  // Issue rules
  // - An op is taken on a rising edge with i_ce, i_valid and not busy
  // - Results, flags and pulses show right after the taking edge itself
  // - Only the disable op makes the block busy, for exactly one cycle
  // - An op offered while busy is dropped without any trace
  // - i_ce low freezes every register, the state machine included
  // Flag policy
  // - Long compare touches N, Z and C only
  // - Aux compare touches the test flag only
  // - Sign count touches N, Z, the test flag and the temporary register
  // - Decrement touches N, Z and C, and sets V only on overflow
  // - Dual MAC takes its flags from the accumulator half alone
  // - V is sticky here; only reset, or op none or an unused code with i_v_in low, clears it
  // - On op none, V is kept only while i_v_in is high
  // Repeat handling
  // - Every op but none and dual MAC pulses the repeat clear
  // - The pulse needs i_repeat_active in the taking cycle
  // - Dual MAC is repeatable, so it never asks for the clear
  // Product shift codes
  // - 0 shifts left by one, 1 passes through, 2 shifts left by four
  // - 3 to 7 shift right arithmetically by one to five
  // - The same shift feeds the compare and both MAC halves
  // Pointer update for the second MAC operand
  // - o_ext_aux_reg_seven_addr carries the pointer value before any update
  // - A first operand update beats the post-increment
  // - Post-increment steps by two words for the 32-bit fetch
  // Hazards and limits
  // - The caller keeps the first MAC operand out of register modes
  // - No trap is raised here if that is broken
  // - The overflow counter wraps silently at six bits
  // - The global mask is only ever set here; clearing lives elsewhere
  // - Aux compares are unsigned on the 16-bit register halves
  // - Memory write data stands for one cycle with its strobe
  // - Pointer write data stands for one cycle with its strobe
  // Timing
  // - The long compare sign comes from a signed 33-bit subtract, the borrow from a separate unsigned one
  // - Products are 16 by 16 signed, giving 32-bit results
  // - Saturation clamps only the accumulator, never the product half
  // - The sign count is a priority chain on the accumulator bits
  // - Flags and results commit together on the same edge

  // ==========================================================
  // State machine for two-cycle interrupt disable
  localparam ST_IDLE = 2'b01;
  localparam ST_DISABLE_INT_OP = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;

  // ==========================================================
  // Product shifter: 0 left one, 1 none, 2 left four, 3..7 arithmetic right 1..5
  function [31:0] pshift;
    input [31:0] v;
    input [2:0]  pm;
    begin
      case (pm)
        3'h0:    pshift = v << 1;
        3'h1:    pshift = v;
        3'h2:    pshift = v << 4;
        default: pshift = $signed(v) >>> (pm - 3'h2);
      endcase
    end
  endfunction

  // Leading identical bit count minus one
  function [4:0] sign_count;
    input [31:0] v;
    integer k;
    reg          stop;
    begin
      sign_count = 5'h00;
      stop = 1'b0;
      for (k = 30; k >= 0; k = k - 1) begin
        if (!stop && (v[k] == v[31]))
          sign_count = sign_count + 5'h01;
        else
          stop = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // Combinational results
  wire [31:0] p_sh    = pshift(o_product_reg, i_product_shift_field);
  wire [32:0] cmp_dif = {o_accumulator_reg[31], o_accumulator_reg} - {p_sh[31], p_sh};
  wire [32:0] cmp_uns = {1'b0, o_accumulator_reg} - {1'b0, p_sh};

  wire [15:0] aux0   = i_aux_regs[15:0];
  wire [15:0] aux_sel = i_aux_regs[i_aux_pointer_field*16 +: 16];

  wire [15:0] dec_res = i_mem16 - 16'h0001;

  wire signed [31:0] prod_hi = $signed(i_op1_32[31:16]) * $signed(i_op2_32[31:16]);
  wire signed [31:0] prod_lo = $signed(i_op1_32[15:0]) * $signed(i_op2_32[15:0]);
  wire [31:0] hi_sh = pshift(prod_hi, i_product_shift_field);
  wire [31:0] lo_sh = pshift(prod_lo, i_product_shift_field);
  wire [32:0] mac_sum = {1'b0, o_accumulator_reg} + {1'b0, hi_sh};
  wire        mac_pov = !o_accumulator_reg[31] && !hi_sh[31] && mac_sum[31];
  wire        mac_nov = o_accumulator_reg[31] && hi_sh[31] && !mac_sum[31];

  reg         compare_aux_op_true;
  always @* begin
    case (i_compare_aux_op_var)
      `CCM_COMPARE_AUX_OP_EQ: compare_aux_op_true = (aux0 == aux_sel);
      `CCM_COMPARE_AUX_OP_GT: compare_aux_op_true = (aux0 > aux_sel);
      `CCM_COMPARE_AUX_OP_LT: compare_aux_op_true = (aux0 < aux_sel);
      default:      compare_aux_op_true = (aux0 != aux_sel);
    endcase
  end

  // State transitions
  always @* begin
    case (state)
      ST_IDLE: next_state = (i_valid && i_op == `CCM_OP_DISABLE_INT_OP) ? ST_DISABLE_INT_OP : ST_IDLE;
      ST_DISABLE_INT_OP: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  assign o_busy = (state == ST_DISABLE_INT_OP);

  wire go = i_ce && i_valid && (state == ST_IDLE);

  // ==========================================================
  // all results and flags commit on one edge
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state                  <= ST_IDLE;
      o_accumulator_reg      <= `CCM_RST_ACC;
      o_product_reg          <= `CCM_RST_P;
      o_temp_reg             <= `CCM_RST_T;
      o_ovc                  <= `CCM_RST_OVC;
      o_flag_n               <= 1'b0;
      o_flag_z               <= 1'b0;
      o_flag_c               <= 1'b0;
      o_flag_v               <= 1'b0;
      o_test_condition_flag  <= 1'b0;
      o_global_int_mask      <= 1'b1;
      o_clear_repeat_counter <= 1'b0;
      o_mem_wdata            <= 16'h0000;
      o_mem_we               <= 1'b0;
      o_ext_aux_reg_seven_addr            <= 22'h000000;
      o_ext_aux_reg_seven_we              <= 1'b0;
      o_ext_aux_reg_seven_new             <= 22'h000000;
    end else if (i_ce) begin
      state                  <= next_state;
      o_mem_we               <= 1'b0;
      o_ext_aux_reg_seven_we              <= 1'b0;
      o_clear_repeat_counter <= 1'b0;
      if (go) begin
        if (i_repeat_active && i_op != `CCM_OP_DUAL_MAC_OP && i_op != `CCM_OP_NONE)
          o_clear_repeat_counter <= 1'b1;
        case (i_op)
          `CCM_OP_COMPARE_LONG_OP: begin
            o_flag_n <= cmp_dif[32];
            o_flag_z <= (cmp_dif[31:0] == 32'h00000000);
            o_flag_c <= !cmp_uns[32];
          end
          `CCM_OP_COMPARE_AUX_OP: begin
            o_test_condition_flag <= compare_aux_op_true;
          end
          `CCM_OP_CSB: begin
            o_temp_reg            <= {11'h000, sign_count(o_accumulator_reg)};
            o_flag_n              <= o_accumulator_reg[31];
            o_flag_z              <= (o_accumulator_reg == 32'h00000000);
            o_test_condition_flag <= o_accumulator_reg[31];
          end
          `CCM_OP_DEC: begin
            o_mem_wdata <= dec_res;
            o_mem_we    <= 1'b1;
            o_flag_n    <= dec_res[15];
            o_flag_z    <= (dec_res == 16'h0000);
            o_flag_c    <= (i_mem16 != 16'h0000);
            if (i_mem16 == 16'h8000)
              o_flag_v <= 1'b1;
          end
          `CCM_OP_DISABLE_INT_OP: begin
            o_global_int_mask <= 1'b1;
          end
          `CCM_OP_DUAL_MAC_OP: begin
            o_product_reg <= o_product_reg + lo_sh;
            o_flag_c      <= mac_sum[32];
            if (mac_pov || mac_nov)
              o_flag_v <= 1'b1;
            if (i_saturate_mode && mac_pov) begin
              o_accumulator_reg <= `CCM_SAT_POS;
              o_flag_n          <= 1'b0;
              o_flag_z          <= 1'b0;
            end else if (i_saturate_mode && mac_nov) begin
              o_accumulator_reg <= `CCM_SAT_NEG;
              o_flag_n          <= 1'b1;
              o_flag_z          <= 1'b0;
            end else begin
              o_accumulator_reg <= mac_sum[31:0];
              o_flag_n          <= mac_sum[31];
              o_flag_z          <= (mac_sum[31:0] == 32'h00000000);
            end
            if (!i_saturate_mode && mac_pov)
              o_ovc <= o_ovc + 6'h01;
            else if (!i_saturate_mode && mac_nov)
              o_ovc <= o_ovc - 6'h01;
            o_ext_aux_reg_seven_addr <= i_ext_aux_reg_seven;
            if (i_op1_mod_ext_aux_reg_seven) begin
              o_ext_aux_reg_seven_we  <= 1'b1;
              o_ext_aux_reg_seven_new <= i_op1_ext_aux_reg_seven_new;
            end else if (i_op2_postinc) begin
              o_ext_aux_reg_seven_we  <= 1'b1;
              o_ext_aux_reg_seven_new <= i_ext_aux_reg_seven + 22'h000002;
            end
          end
          default: begin
            o_flag_v <= i_v_in & o_flag_v;
          end
        endcase
      end
    end
  end

endmodule // ccm_datapath

// >>> ccm_defs.vh
// Constants for the compare, count and multiply-accumulate datapath
`ifndef CCM_DEFS_VH
`define CCM_DEFS_VH
// Operation codes on i_op
`define CCM_OP_NONE     4'h0
`define CCM_OP_COMPARE_LONG_OP     4'h1
`define CCM_OP_COMPARE_AUX_OP     4'h2
`define CCM_OP_CSB      4'h3
`define CCM_OP_DEC      4'h4
`define CCM_OP_DISABLE_INT_OP     4'h5
`define CCM_OP_DUAL_MAC_OP     4'h6
// Aux compare variants
`define CCM_COMPARE_AUX_OP_EQ     2'h0
`define CCM_COMPARE_AUX_OP_GT     2'h1
`define CCM_COMPARE_AUX_OP_LT     2'h2
`define CCM_COMPARE_AUX_OP_NE     2'h3
// Saturation limits
`define CCM_SAT_POS     32'h7FFFFFFF
`define CCM_SAT_NEG     32'h80000000
// Reset values
`define CCM_RST_ACC     32'h00000000
`define CCM_RST_P       32'h00000000
`define CCM_RST_T       16'h0000
`define CCM_RST_OVC     6'h00
// Interrupt disable takes two cycles
`define CCM_DISABLE_INT_OP_CYC    2'h2
`endif

// >>> ccm_datapath_monitor.sv
// Port checker for the compare, count and MAC datapath
`timescale 1ns/1ps
`include "ccm_defs.vh"
module ccm_monitor (
  input wire         i_clk,
  input wire         i_rst,
  input wire         i_ce,
  input wire         i_valid,
  input wire [3:0]   i_op,
  input wire [1:0]   i_compare_aux_op_var,
  input wire         i_repeat_active,
  input wire [2:0]   i_aux_pointer_field,
  input wire [127:0] i_aux_regs,
  input wire [15:0]  i_mem16,
  input wire [31:0]  o_accumulator_reg,
  input wire [31:0]  o_product_reg,
  input wire         o_flag_n,
  input wire         o_flag_z,
  input wire         o_flag_c,
  input wire         o_test_condition_flag,
  input wire         o_global_int_mask,
  input wire         o_clear_repeat_counter,
  input wire [15:0]  o_mem_wdata,
  input wire         o_mem_we,
  input wire         o_busy
);
  // ==========
  // Issue and aux compare helpers
  wire        take = i_ce & i_valid & ~o_busy;
  wire [15:0] ar0  = i_aux_regs[15:0];
  wire [15:0] aux_pointer_field  = i_aux_regs[i_aux_pointer_field*16 +: 16];
  wire        hit  = (i_compare_aux_op_var == `CCM_COMPARE_AUX_OP_EQ) ? (ar0 == aux_pointer_field) : (i_compare_aux_op_var == `CCM_COMPARE_AUX_OP_GT) ? (ar0 > aux_pointer_field) :
                     (i_compare_aux_op_var == `CCM_COMPARE_AUX_OP_LT) ? (ar0 < aux_pointer_field) : (ar0 != aux_pointer_field);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // Assertions
  a_disable_int_op_mask_busy: assert property (take && i_op == `CCM_OP_DISABLE_INT_OP |=> o_global_int_mask && o_busy)
    else $error("mask or busy missing after disable");
  a_busy_one_cycle: assert property (o_busy && i_ce |=> !o_busy)
    else $error("busy held too long");
  a_mask_holds: assert property (o_global_int_mask |=> o_global_int_mask)
    else $error("mask dropped");
  a_compare_long_op_keeps_regs: assert property (take && i_op == `CCM_OP_COMPARE_LONG_OP |=> $stable(o_accumulator_reg) && $stable(o_product_reg))
    else $error("compare changed a register");
  a_dec_write_back: assert property (take && i_op == `CCM_OP_DEC |=> o_mem_we && o_mem_wdata == $past(i_mem16) - 16'h0001)
    else $error("decrement result wrong");
  a_dec_flag_set: assert property (take && i_op == `CCM_OP_DEC |=> o_flag_z == (o_mem_wdata == 16'h0000)
    && o_flag_n == o_mem_wdata[15] && o_flag_c == ($past(i_mem16) != 16'h0000))
    else $error("decrement flags wrong");
  a_compare_aux_op_test_flag: assert property (take && i_op == `CCM_OP_COMPARE_AUX_OP |=> o_test_condition_flag == $past(hit))
    else $error("aux compare test flag wrong");
  a_csb_sign_flags: assert property (take && i_op == `CCM_OP_CSB |=> o_flag_n == $past(o_accumulator_reg[31])
    && o_test_condition_flag == o_flag_n && o_flag_z == ($past(o_accumulator_reg) == 32'h00000000))
    else $error("sign count flags wrong");
  a_repeat_clear: assert property (take && i_repeat_active && i_op >= `CCM_OP_COMPARE_LONG_OP && i_op <= `CCM_OP_DISABLE_INT_OP
    |=> o_clear_repeat_counter)
    else $error("repeat counter not cleared");
  cover property (take && i_op == `CCM_OP_DISABLE_INT_OP);
  cover property (take && i_op == `CCM_OP_DUAL_MAC_OP);
  cover property (o_clear_repeat_counter);
endmodule // ccm_monitor
bind ccm_datapath ccm_monitor u_mon (.i_clk, .i_rst, .i_ce, .i_valid, .i_op, .i_compare_aux_op_var, .i_repeat_active,
  .i_aux_pointer_field, .i_aux_regs, .i_mem16, .o_accumulator_reg, .o_product_reg, .o_flag_n, .o_flag_z,
  .o_flag_c, .o_test_condition_flag, .o_global_int_mask, .o_clear_repeat_counter, .o_mem_wdata, .o_mem_we, .o_busy);

// >>> tb.sv
// Directed testbench for the compare, count and MAC datapath
`timescale 1ns/1ps
`include "ccm_defs.vh"
module tb;
  reg          i_clk, i_rst, i_valid, i_repeat_active, i_op1_mod_ext_aux_reg_seven, i_op2_postinc;
  reg          i_ce, i_saturate_mode;
  reg  [3:0]   i_op;
  reg  [1:0]   i_compare_aux_op_var;
  reg  [2:0]   i_product_shift_field, i_aux_pointer_field;
  reg  [127:0] i_aux_regs;
  reg  [15:0]  i_mem16, m, w, b;
  reg  [31:0]  i_op1_32, i_op2_32;
  reg  [21:0]  i_op1_ext_aux_reg_seven_new;
  wire [31:0]  o_accumulator_reg, o_product_reg;
  wire [15:0]  o_temp_reg, o_mem_wdata;
  wire [5:0]   o_ovc;
  wire [21:0]  o_ext_aux_reg_seven_addr, o_ext_aux_reg_seven_new;
  wire         o_flag_n, o_flag_z, o_flag_c, o_flag_v, o_test_condition_flag, o_global_int_mask;
  wire         o_clear_repeat_counter, o_mem_we, o_ext_aux_reg_seven_we, o_busy;
  integer      bad_count, check_count, k, p, v;
  ccm_datapath DUT (.i_clk, .i_rst, .i_ce, .i_valid, .i_op, .i_compare_aux_op_var, .i_repeat_active,
    .i_product_shift_field, .i_saturate_mode, .i_aux_pointer_field, .i_aux_regs, .i_mem16, .i_op1_32,
    .i_op2_32, .i_ext_aux_reg_seven(22'h000100), .i_op1_mod_ext_aux_reg_seven, .i_op1_ext_aux_reg_seven_new, .i_op2_postinc,
    .i_c_in(1'b0), .i_v_in(1'b1), .o_accumulator_reg, .o_product_reg, .o_temp_reg, .o_ovc, .o_flag_n,
    .o_flag_z, .o_flag_c, .o_flag_v, .o_test_condition_flag, .o_global_int_mask, .o_clear_repeat_counter,
    .o_mem_wdata, .o_mem_we, .o_ext_aux_reg_seven_addr, .o_ext_aux_reg_seven_we, .o_ext_aux_reg_seven_new, .o_busy);
  // ==========
  // Shared tasks
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One-cycle issue; valid stays up so back-to-back calls never toggle it in one step
  task issue(input [3:0] op);
    begin
      i_valid = 1'b1;
      i_op = op;
      @(posedge i_clk);
      #2;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ==========
  // Main sequence
  initial begin
    {i_valid, i_repeat_active, i_op1_mod_ext_aux_reg_seven, i_op2_postinc, i_compare_aux_op_var} = 0;
    {i_op, i_aux_pointer_field, i_mem16, i_op1_32, i_op2_32, i_op1_ext_aux_reg_seven_new} = 0;
    i_product_shift_field = 3'h1;
    i_ce = 1'b1;
    i_saturate_mode = 1'b0;
    i_aux_regs = {80'h0, 16'h0100, 16'h1111, 16'h2222, 16'h1111};
    bad_count = 0;
    check_count = 0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #2 i_rst = 1'b0;
    chk(o_global_int_mask, 1);
    for (k = 0; k < 3; k = k + 1) begin
      m = (k == 0) ? 16'h0001 : (k == 1) ? 16'h0000 : 16'h8000;
      w = m - 16'h0001;
      i_mem16 = m;
      i_repeat_active = (k == 1);
      issue(`CCM_OP_DEC);
      chk({o_mem_we, o_mem_wdata}, {1'b1, w});
      chk({o_flag_n, o_flag_z, o_flag_v}, {w[15], w == 16'h0000, m == 16'h8000});
      chk(o_flag_c, m != 16'h0000);
      chk(o_clear_repeat_counter, k == 1);
    end
    $display("decrement done");
    for (p = 1; p < 4; p = p + 1) for (v = 0; v < 4; v = v + 1) begin
      i_aux_pointer_field = p[2:0];
      i_compare_aux_op_var = v[1:0];
      b = i_aux_regs[p*16 +: 16];
      issue(`CCM_OP_COMPARE_AUX_OP);
      chk(o_test_condition_flag, (v == 0) ? (b == 16'h1111) : (v == 1) ? (16'h1111 > b) :
        (v == 2) ? (16'h1111 < b) : (b != 16'h1111));
    end
    $display("aux compare done");
    {i_op1_32, i_op2_32, i_op2_postinc, i_repeat_active} = {32'h00030002, 32'hFFFE0005, 2'b11};
    issue(`CCM_OP_DUAL_MAC_OP); // first operand comes from memory
    chk(o_accumulator_reg, 32'hFFFFFFFA);
    chk(o_product_reg, 32'h0000000A);
    chk({o_flag_n, o_flag_z, o_clear_repeat_counter}, 3'b100);
    chk({o_ext_aux_reg_seven_we, o_ext_aux_reg_seven_new}, {1'b1, 22'h000102});
    {i_op1_32, i_op2_32, i_product_shift_field, i_op1_mod_ext_aux_reg_seven} = {32'h00010001, 32'hFFFD0003, 3'h3, 1'b1};
    i_op1_ext_aux_reg_seven_new = 22'h000200;
    i_repeat_active = 1'b0;
    issue(`CCM_OP_DUAL_MAC_OP);
    chk(o_accumulator_reg, 32'hFFFFFFF8);
    chk(o_product_reg, 32'h0000000B);
    chk(o_ext_aux_reg_seven_new, 22'h000200);
    i_product_shift_field = 3'h1;
    issue(`CCM_OP_COMPARE_LONG_OP);
    chk(o_accumulator_reg, 32'hFFFFFFF8);
    chk(o_product_reg, 32'h0000000B);
    chk({o_flag_n, o_flag_z, o_flag_c}, 3'b101);
    issue(`CCM_OP_CSB);
    chk(o_temp_reg, 16'h001C);
    chk({o_flag_n, o_flag_z, o_test_condition_flag}, 3'b101);
    i_ce = 1'b0;
    i_mem16 = 16'h0005;
    issue(`CCM_OP_DEC);
    chk({o_mem_we, o_flag_n, o_temp_reg}, {2'b01, 16'h001C});
    i_ce = 1'b1;
    $display("mac compare count done");
    i_repeat_active = 1'b1;
    issue(`CCM_OP_DISABLE_INT_OP);
    chk({o_busy, o_global_int_mask, o_clear_repeat_counter}, 3'b111);
    i_repeat_active = 1'b0;
    issue(`CCM_OP_DEC);
    chk(o_mem_we, 0);
    $display("interrupt disable done");
    {i_op1_32, i_op2_32, i_product_shift_field, i_op1_mod_ext_aux_reg_seven} = {32'h7FFF0000, 32'h7FFF0000, 3'h0, 1'b0};
    issue(`CCM_OP_DUAL_MAC_OP);
    chk(o_accumulator_reg, 32'h7FFDFFFA);
    i_saturate_mode = 1'b1;
    issue(`CCM_OP_DUAL_MAC_OP);
    chk(o_accumulator_reg, 32'h7FFFFFFF);
    chk(o_ovc, 6'h00);
    i_saturate_mode = 1'b0;
    issue(`CCM_OP_DUAL_MAC_OP);
    chk(o_accumulator_reg, 32'hFFFE0001);
    chk(o_ovc, 6'h01);
    $display("saturation done");
    conclude;
  end
endmodule // tb
